// ### hdl/sac_step_atten_ctrl.sv
// Purpose: serial programming and preset selection of a step attenuator
// Assumes: 10 MHz clk_sys, serial clock far slower (800 ns bench period)
// Notes:   frame layout is in sac_pkg
//          serial pins and fast preset select pass three flip-flops each
//          strap levels and open flags come from the same clock domain
//          a frame commits only with sixteen or more bits counted
//          more than sixteen bits keep the last sixteen shifted
//          preset frames leave the programmed code untouched
//          normal frames leave the stored preset untouched
//          applied code loads in the same cycle as the selected stored code
//          no status shows a refused frame
// Function
// - attenuation is a seven-bit code of quarter-decibel steps up to 31.75 dB.
// - the device answers only to the address on its three strap pins.
// - after reset the attenuation is full scale until reprogrammed.
// - an open lowest strap pin reads as zero.
// - while fast preset select is high the preset value is applied.
// - the preset defaults to full scale until programmed.
// - when fast preset select falls the programmed code returns.
// - data shifts in only while the latch strobe is low.
// - a low-high-low strobe commits the shifted frame.
// - an open latch strobe reads as high so nothing shifts; the design has no open input for it, its synchroniser only resets high.
// - open upper strap pins read as one.
`timescale 1ns/1ps
module sac_step_atten_ctrl
	import sac_pkg::*;
(
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	input  wire logic               serialClock,
	input  wire logic               serialData,
	input  wire logic               latchStrobe,
	input  wire logic               addressStrapBitZero,
	input  wire logic               addressStrapBitOne,
	input  wire logic               addressStrapBitTwo,
	input  wire logic               addressStrapZeroOpen,
	input  wire logic               addressStrapOneOpen,
	input  wire logic               addressStrapTwoOpen,
	input  wire logic               fastPresetSelect,
	output logic [ATTEN_W-1:0]      stepAttenuatorCode,
	output logic [ATTEN_W-1:0]      programmedCode,
	output logic [ATTEN_W-1:0]      presetCode,
	output logic                    frameCommitted
);
	sac_if pins ();

	sac_pin_sync u_sync
	(
		.clk_sys     (clk_sys),
		.rstn        (rstn),
		.serialClock (serialClock),
		.serialData  (serialData),
		.latchStrobe (latchStrobe),
		.pins        (pins.sync)
	);

	// strap resolution, open pins take their pull value
	function automatic logic [ADDR_W-1:0] strapAddr(input logic b0, input logic b1,
		input logic b2, input logic o0, input logic o1, input logic o2);
		logic [ADDR_W-1:0] a;
		a[0] = o0 ? 1'b0 : b0;
		a[1] = o1 ? 1'b1 : b1;
		a[2] = o2 ? 1'b1 : b2;
		return a;
	endfunction : strapAddr

	// fast preset select: three stages, agree on two and three
	logic [SYNC_W-1:0] fpS_q, fpS_d;
	logic              fpSt_q, fpSt_d;
	logic [ADDR_W-1:0] addr_q, addr_d;

	always_comb
	begin
		fpS_d  = {fpS_q[1:0], fastPresetSelect};
		fpSt_d = (fpS_q[1] == fpS_q[2]) ? fpS_q[2] : fpSt_q;
		addr_d = strapAddr(addressStrapBitZero, addressStrapBitOne, addressStrapBitTwo,
			addressStrapZeroOpen, addressStrapOneOpen, addressStrapTwoOpen);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			fpS_q  <= SYNC_RST_LOW;
			fpSt_q <= 1'b0;
			addr_q <= '0;
		end
		else
		begin
			fpS_q  <= fpS_d;
			fpSt_q <= fpSt_d;
			addr_q <= addr_d;
		end
	end

	// frame shifter and commit state
	logic [FRAME_W-1:0] shift_q, shift_d;
	logic [CNT_W-1:0]   cnt_q, cnt_d;
	logic [ATTEN_W-1:0] prog_q, prog_d, preset_q, preset_d, out_q, out_d;
	logic               commit_q, commit_d;
	logic               frameOk;

	always_comb
	begin
		shift_d  = shift_q;
		cnt_d    = cnt_q;
		prog_d   = prog_q;
		preset_d = preset_q;
		commit_d = 1'b0;
		frameOk  = (cnt_q == FRAME_LEN)
			&& (shift_q[ADDR_HI:ADDR_LO] == addr_q);
		if (!pins.latchLvl && pins.sclkRise)
		begin
			shift_d = {shift_q[FRAME_W-2:0], pins.sdata};
			if (cnt_q != FRAME_LEN)
				cnt_d = cnt_q + CNT_ONE;
		end
		if (pins.latchFall)
		begin
			cnt_d = CNT_ZERO;
			if (frameOk)
			begin
				commit_d = 1'b1;
				if (shift_q[PRESET_BIT])
					preset_d = shift_q[CODE_HI:0];
				else
					prog_d = shift_q[CODE_HI:0];
			end
		end
		out_d = fpSt_q ? preset_d : prog_d;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			shift_q  <= SHIFT_RST;
			cnt_q    <= CNT_ZERO;
			prog_q   <= ATTEN_MAX;
			preset_q <= ATTEN_MAX;
			out_q    <= ATTEN_MAX;
			commit_q <= 1'b0;
		end
		else
		begin
			shift_q  <= shift_d;
			cnt_q    <= cnt_d;
			prog_q   <= prog_d;
			preset_q <= preset_d;
			out_q    <= out_d;
			commit_q <= commit_d;
		end
	end

	assign stepAttenuatorCode = out_q;
	assign programmedCode     = prog_q;
	assign presetCode         = preset_q;
	assign frameCommitted     = commit_q;

	// assertions
	property p_reset_full;
		@(posedge clk_sys) $rose(rstn) |-> (out_q == ATTEN_MAX && preset_q == ATTEN_MAX);
	endproperty
	a_reset_full: assert property (p_reset_full) else $error("reset not full scale");

	property p_preset_apply;
		@(posedge clk_sys) disable iff (!rstn) fpSt_q |=> (out_q == $past(preset_d));
	endproperty
	a_preset_apply: assert property (p_preset_apply) else $error("preset not applied");

	// preset released, programmed code back at once
	property p_restore;
		@(posedge clk_sys) disable iff (!rstn) $fell(fpSt_q) |=> (out_q == $past(prog_d));
	endproperty
	a_restore: assert property (p_restore) else $error("code not restored after preset");

	// applied code tracks preset while selected
	property p_preset_follow;
		@(posedge clk_sys) disable iff (!rstn) fpSt_q |=> (out_q == preset_q);
	endproperty
	a_preset_follow: assert property (p_preset_follow) else $error("applied code not preset");

	// applied code tracks programmed code otherwise
	property p_prog_follow;
		@(posedge clk_sys) disable iff (!rstn) !fpSt_q |=> (out_q == prog_q);
	endproperty
	a_prog_follow: assert property (p_prog_follow) else $error("applied code not programmed");

	// commit is a single-cycle pulse
	property p_commit_pulse;
		@(posedge clk_sys) disable iff (!rstn) commit_q |=> !commit_q;
	endproperty
	a_commit_pulse: assert property (p_commit_pulse) else $error("commit longer than one cycle");

	// stored preset only moves on a commit
	property p_preset_stable;
		@(posedge clk_sys) disable iff (!rstn) !commit_q |-> (preset_q == $past(preset_q));
	endproperty
	a_preset_stable: assert property (p_preset_stable) else $error("preset moved without commit");

	// short frames never commit
	property p_short_frame;
		@(posedge clk_sys) disable iff (!rstn) (pins.latchFall && cnt_q != FRAME_LEN) |=> !commit_q;
	endproperty
	a_short_frame: assert property (p_short_frame) else $error("short frame committed");

	// bit counter saturates at frame length
	property p_cnt_bound;
		@(posedge clk_sys) disable iff (!rstn) (cnt_q <= FRAME_LEN);
	endproperty
	a_cnt_bound: assert property (p_cnt_bound) else $error("bit count past frame length");

	// strobe fall restarts the bit count
	property p_cnt_clear;
		@(posedge clk_sys) disable iff (!rstn) pins.latchFall |=> (cnt_q == CNT_ZERO);
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared by strobe");

	// newest bit enters at the bottom
	property p_shift_in;
		@(posedge clk_sys) disable iff (!rstn)
			(!pins.latchLvl && pins.sclkRise) |=> (shift_q[0] == $past(pins.sdata));
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

	// no serial clock rise, no shift
	property p_shift_hold;
		@(posedge clk_sys) disable iff (!rstn) !pins.sclkRise |=> (shift_q == $past(shift_q));
	endproperty
	a_shift_hold: assert property (p_shift_hold) else $error("shift without clock rise");

	// normal frame loads the programmed code
	property p_commit_code;
		@(posedge clk_sys) disable iff (!rstn)
			(commit_q && !$past(shift_q[PRESET_BIT])) |-> (prog_q == $past(shift_q[CODE_HI:0]));
	endproperty
	a_commit_code: assert property (p_commit_code) else $error("committed code wrong");

	// preset frame loads the preset code
	property p_commit_preset;
		@(posedge clk_sys) disable iff (!rstn)
			(commit_q && $past(shift_q[PRESET_BIT])) |-> (preset_q == $past(shift_q[CODE_HI:0]));
	endproperty
	a_commit_preset: assert property (p_commit_preset) else $error("committed preset wrong");

	// preset frame leaves the programmed code
	property p_preset_keeps_prog;
		@(posedge clk_sys) disable iff (!rstn)
			(commit_q && $past(shift_q[PRESET_BIT])) |-> (prog_q == $past(prog_q));
	endproperty
	a_preset_keeps_prog: assert property (p_preset_keeps_prog) else $error("preset hit code");

	// driven strap zero is taken as is
	property p_strap_zero_drv;
		@(posedge clk_sys) disable iff (!rstn)
			!addressStrapZeroOpen |=> (addr_q[0] == $past(addressStrapBitZero));
	endproperty
	a_strap_zero_drv: assert property (p_strap_zero_drv) else $error("strap zero not taken");

	// driven strap one is taken as is
	property p_strap_one_drv;
		@(posedge clk_sys) disable iff (!rstn)
			!addressStrapOneOpen |=> (addr_q[1] == $past(addressStrapBitOne));
	endproperty
	a_strap_one_drv: assert property (p_strap_one_drv) else $error("strap one not taken");

	// reset release leaves full scale and idle strobe
	property p_reset_prog;
		@(posedge clk_sys) $rose(rstn) |-> (prog_q == ATTEN_MAX && !commit_q && pins.latchLvl);
	endproperty
	a_reset_prog: assert property (p_reset_prog) else $error("reset state wrong");

	property p_normal;
		@(posedge clk_sys) disable iff (!rstn) !fpSt_q |=> (out_q == $past(prog_d));
	endproperty
	a_normal: assert property (p_normal) else $error("programmed code not restored");

	property p_no_shift_high;
		@(posedge clk_sys) disable iff (!rstn) pins.latchLvl |=> (shift_q == $past(shift_q));
	endproperty
	a_no_shift_high: assert property (p_no_shift_high) else $error("shift while strobe high");

	property p_commit_only_fall;
		@(posedge clk_sys) disable iff (!rstn) commit_q |-> $past(pins.latchFall);
	endproperty
	a_commit_only_fall: assert property (p_commit_only_fall) else $error("commit without strobe");

	property p_addr_match;
		@(posedge clk_sys) disable iff (!rstn)
			commit_d |-> (shift_q[ADDR_HI:ADDR_LO] == addr_q);
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("commit to foreign address");

	property p_prog_stable;
		@(posedge clk_sys) disable iff (!rstn) !commit_q |-> (prog_q == $past(prog_q));
	endproperty
	a_prog_stable: assert property (p_prog_stable) else $error("code changed without commit");

	property p_strap_zero;
		@(posedge clk_sys) disable iff (!rstn)
			addressStrapZeroOpen |=> (addr_q[0] == 1'b0);
	endproperty
	a_strap_zero: assert property (p_strap_zero) else $error("open strap zero not low");

	property p_strap_hi;
		@(posedge clk_sys) disable iff (!rstn)
			(addressStrapOneOpen && addressStrapTwoOpen) |=> (addr_q[2:1] == 2'h3);
	endproperty
	a_strap_hi: assert property (p_strap_hi) else $error("open upper straps not high");
endmodule : sac_step_atten_ctrl

// ### hdl/sac_pkg.sv
// Purpose: shared constants and types for the step attenuator serial control
// Assumes: 16-bit frame, msb first: [15] preset flag, [14:12] address, [11:7] spare, [6:0] code
// Notes:   all counts and field positions live here
package sac_pkg;
	localparam int        ATTEN_W       = 7;                 // 0.25 dB per lsb
	localparam int        ADDR_W        = 3;
	localparam int        FRAME_W       = 16;
	localparam int        CNT_W         = 5;
	localparam int        SYNC_W        = 3;
	localparam logic [6:0] ATTEN_MAX    = 7'h7f;            // 31.75 dB
	localparam int        PRESET_BIT    = 15;
	localparam int        ADDR_HI       = 14;
	localparam int        ADDR_LO       = 12;
	localparam int        CODE_HI       = 6;
	localparam logic [4:0] FRAME_LEN    = 5'h10;
	localparam logic [4:0] CNT_ZERO     = 5'h00;
	localparam logic [4:0] CNT_ONE      = 5'h01;
	localparam logic [2:0] SYNC_RST_LOW = 3'h0;
	localparam logic [2:0] SYNC_RST_HI  = 3'h7;
	localparam logic [15:0] SHIFT_RST   = 16'h0000;
endpackage : sac_pkg

// ### hdl/sac_if.sv
// Purpose: carries the synchronised serial pins between modules
// Assumes: all signals on clk_sys
// Notes:   sync side drives, core side reads
`timescale 1ns/1ps
interface sac_if;
	logic sclkRise;
	logic sdata;
	logic latchLvl;
	logic latchFall;
	modport sync (output sclkRise, output sdata, output latchLvl, output latchFall);
	modport core (input sclkRise, input sdata, input latchLvl, input latchFall);
endinterface : sac_if

// ### hdl/sac_pin_sync.sv
// Purpose: three-stage synchronisers and edge finding for serial pins
// Assumes: pins asynchronous to clk_sys
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
module sac_pin_sync
	import sac_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic serialClock,
	input  wire logic serialData,
	input  wire logic latchStrobe,
	sac_if.sync       pins
);
	logic [SYNC_W-1:0] ckS_q, ckS_d, dS_q, dS_d, leS_q, leS_d;
	logic              ckSt_q, ckSt_d, dSt_q, dSt_d, leSt_q, leSt_d;

	// shift chains and filtered levels
	always_comb
	begin
		ckS_d  = {ckS_q[1:0], serialClock};
		dS_d   = {dS_q[1:0], serialData};
		leS_d  = {leS_q[1:0], latchStrobe};
		ckSt_d = (ckS_q[1] == ckS_q[2]) ? ckS_q[2] : ckSt_q;
		dSt_d  = (dS_q[1] == dS_q[2]) ? dS_q[2] : dSt_q;
		leSt_d = (leS_q[1] == leS_q[2]) ? leS_q[2] : leSt_q;
	end

	// registers; latch strobe idles high as if pulled up
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			ckS_q  <= SYNC_RST_LOW;
			dS_q   <= SYNC_RST_LOW;
			leS_q  <= SYNC_RST_HI;
			ckSt_q <= 1'b0;
			dSt_q  <= 1'b0;
			leSt_q <= 1'b1;
		end
		else
		begin
			ckS_q  <= ckS_d;
			dS_q   <= dS_d;
			leS_q  <= leS_d;
			ckSt_q <= ckSt_d;
			dSt_q  <= dSt_d;
			leSt_q <= leSt_d;
		end
	end

	// edge pulses from stable levels
	assign pins.sclkRise  = ckSt_d & ~ckSt_q;
	assign pins.sdata     = dSt_q;
	assign pins.latchLvl  = leSt_q;
	assign pins.latchFall = ~leSt_d & leSt_q;
endmodule : sac_pin_sync

// ### test/sac_host_model.sv
// Purpose: host model driving the shared serial programming bus
// Assumes: clk_sys 100 ns, serial clock halves of four cycles (800 ns period)
// Notes:   serial clock stands low between frames, strobe idles high
`timescale 1ns/1ps
module sac_host_model (
	input  wire logic clk_sys,
	output logic      serialClock,
	output logic      serialData,
	output logic      latchStrobe
);
	// idle pin levels at time zero
	initial
	begin
		serialClock = 1'b0;
		serialData  = 1'b0;
		latchStrobe = 1'b1; // pull-up level
	end
	// wait n edges, then step off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	// shift a frame msb first, then a low-high-low commit
	task automatic send_frame(input logic [15:0] f, input logic lowWhileShift);
		latchStrobe = ~lowWhileShift;
		for (int i = 15; i >= 0; i--)
		begin
			serialData  = f[i]; // data changes while clock is low
			tick(4);
			serialClock = 1'b1;
			tick(4);
			serialClock = 1'b0;
		end
		serialData  = ~f[0]; // released line shows no stale bit
		latchStrobe = 1'b0;
		tick(4);
		latchStrobe = 1'b1;
		tick(4);
		latchStrobe = 1'b0;
		tick(12);
		latchStrobe = 1'b1; // back to idle
		tick(4);
	endtask : send_frame
endmodule : sac_host_model

// ### test/tb_top.sv
// Purpose: self-checking bench for the step attenuator serial control
// Assumes: design address straps set per scenario, reset after strap change
// Notes:   expected codes are literal values matching the frames sent
`timescale 1ns/1ps
module tb_top
	import sac_pkg::*;
;
	logic             clk_sys;
	logic             rstn;
	logic             sClk;
	logic             sData;
	logic             latch;
	logic [2:0]       strap;
	logic [2:0]       strapOpen;
	logic             fastPreset;
	logic [ATTEN_W-1:0] stepCode;
	logic [ATTEN_W-1:0] progCode;
	logic [ATTEN_W-1:0] preCode;
	logic             committed;
	int               commits;
	int               cycles;
	int               miscompares;
	int               comparisons;
	// clock source
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	sac_host_model host (.clk_sys(clk_sys), .serialClock(sClk), .serialData(sData),
		.latchStrobe(latch));
	sac_step_atten_ctrl uut (.clk_sys(clk_sys), .rstn(rstn), .serialClock(sClk),
		.serialData(sData), .latchStrobe(latch), .addressStrapBitZero(strap[0]),
		.addressStrapBitOne(strap[1]), .addressStrapBitTwo(strap[2]),
		.addressStrapZeroOpen(strapOpen[0]), .addressStrapOneOpen(strapOpen[1]),
		.addressStrapTwoOpen(strapOpen[2]), .fastPresetSelect(fastPreset),
		.stepAttenuatorCode(stepCode), .programmedCode(progCode),
		.presetCode(preCode), .frameCommitted(committed));
	// commit pulse count and hang limit
	always @(posedge clk_sys)
	begin
		cycles++;
		if (rstn !== 1'b1)
			commits <= 0;
		else if (committed === 1'b1)
			commits <= commits + 1;
		if (cycles == 5000)
		begin
			miscompares++;
			results();
		end
	end
	task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// all three codes and the commit count
	task automatic codes(input logic [6:0] s, input logic [6:0] p, input logic [6:0] r,
		input int n);
		check("stepAttenuatorCode", s, stepCode);
		check("programmedCode", p, progCode);
		check("presetCode", r, preCode);
		check("frameCommitted count", 7'(n), 7'(commits));
	endtask : codes
	function automatic logic [15:0] frm(input logic pf, input logic [2:0] a,
		input logic [6:0] c);
		return {pf, a, 5'h00, c};
	endfunction : frm
	task automatic do_reset;
		rstn = 1'b0;
		host.tick(10);
		rstn = 1'b1;
		host.tick(6);
	endtask : do_reset
	task automatic results;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	// main sequence
	initial
	begin
		rstn = 1'b0;
		strap = 3'h5;
		strapOpen = 3'h0;
		fastPreset = 1'b0;
		commits = 0;
		cycles = 0;
		miscompares = 0;
		comparisons = 0;
		do_reset();
		codes(7'h7f, 7'h7f, 7'h7f, 0);
		fastPreset = 1'b1;
		host.tick(8);
		check("stepAttenuatorCode", 7'h7f, stepCode);
		fastPreset = 1'b0;
		host.tick(8);
		host.send_frame(frm(1'b0, 3'h5, 7'h2a), 1'b1);
		codes(7'h2a, 7'h2a, 7'h7f, 1);
		host.send_frame(frm(1'b0, 3'h4, 7'h11), 1'b1);
		codes(7'h2a, 7'h2a, 7'h7f, 1);
		host.send_frame(frm(1'b0, 3'h5, 7'h11), 1'b0);
		codes(7'h2a, 7'h2a, 7'h7f, 1);
		host.send_frame(frm(1'b1, 3'h5, 7'h15), 1'b1);
		codes(7'h2a, 7'h2a, 7'h15, 2);
		fastPreset = 1'b1;
		host.tick(8);
		check("stepAttenuatorCode", 7'h15, stepCode);
		fastPreset = 1'b0;
		host.tick(8);
		check("stepAttenuatorCode", 7'h2a, stepCode);
		strap = 3'h1;
		strapOpen = 3'h7;
		do_reset();
		codes(7'h7f, 7'h7f, 7'h7f, 0);
		host.send_frame(frm(1'b0, 3'h6, 7'h00), 1'b1);
		codes(7'h00, 7'h00, 7'h7f, 1);
		strap = 3'h2;
		strapOpen = 3'h0;
		do_reset();
		host.send_frame(frm(1'b0, 3'h6, 7'h44), 1'b1);
		codes(7'h7f, 7'h7f, 7'h7f, 0);
		host.send_frame(frm(1'b0, 3'h2, 7'h33), 1'b1);
		codes(7'h33, 7'h33, 7'h7f, 1);
		results();
	end
endmodule : tb_top
